// >>> inc/lpd_pkg.sv
// constants, field layout and types for the led pwm display-timing block
package lpd_pkg;
  // serial frame and data latch layout
  localparam int SR_W          = 224;
  localparam int LATCH_W       = 218;
  localparam int CMD_W         = 6;
  localparam int BIT_EDGE_SEL  = 217;
  localparam int BIT_EXT_CLK   = 216;
  localparam int BIT_TMG_RST   = 215;
  localparam int BIT_REPEAT    = 214;
  localparam int BIT_BLANK     = 213;
  localparam int BC_LSB        = 192;
  localparam int BC_W          = 7;
  localparam int BC_GROUPS     = 3;
  localparam int GS_W          = 16;
  localparam int CHANNELS      = 12;
  localparam logic [GS_W-1:0] GS_LAST = 16'hffff;

  // latch delay, counted in internal oscillator periods
  localparam int LATCH_MIN_OSC = 8;
  localparam int LATCH_MAX_OSC = 16384;
  localparam int IDLE_W        = 15;

  // internal oscillator: half period in clk cycles after reset
  localparam logic [7:0] OSC_DIV_RST = 8'h01;
  localparam int         FIFO_DEPTH  = 16;
  localparam int         FIFO_CNT_W  = 5;

  // apb register map
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_COUNT  = 8'h08;
  localparam int CTRL_DIV_LSB  = 0;
  localparam int CTRL_HOLD_BIT = 8;

  // display period state, gray coded along idle -> run -> done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b11
  } lpd_state_e;

  // grayscale value of one channel out of the data latch
  function automatic logic [GS_W-1:0] gs_field(
    input logic [LATCH_W-1:0] latch,
    input int                 ch
  );
    gs_field = latch[ch*GS_W +: GS_W];
  endfunction
endpackage

// >>> core/lpd_sync.sv
// two-flop synchroniser for signals from outside the clk domain
`timescale 1ns/100ps
module lpd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule // lpd_sync

// >>> core/lpd_fifo.sv
// parameterised valid/ready fifo between frame capture and data latch
`timescale 1ns/100ps
module lpd_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16,
  parameter int CW    = $clog2(DEPTH) + 1
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic      [W-1:0]  out_data,
  output logic      [CW-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;

  assign in_ready  = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  // storage has no reset; only pointers and count need a defined value
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end
endmodule // lpd_fifo

// >>> core/lpd_top.sv
// led sink driver display timing: serial frame, latch, pwm and apb status
// Operation
// - repeat bit set restarts the display period endlessly while clock runs
// - repeat bit clear runs one period after unblank or timing reset
// - display period advances only on grayscale clock edges
// - timing reset bit set: latch pulse clears counter and forces outputs off
// - timing reset bit clear: latch pulse leaves counter and outputs alone
// - after timing reset pwm restarts at next grayscale clock edge
// - any change of the blank bit acts like a timing reset
// - edge select set: outputs switch on grayscale clock rising edges
// - edge select clear: outputs switch on grayscale clock falling edges
// - latch pulse timed from last serial clock rise, not the 224th
// - outputs follow latched grayscale data, never the shift register
// - brightness per colour group; internal or external grayscale clock
// - latch pulse 8 to 16384 oscillator periods after last clock rise
// - blank bit set at power-on so all outputs start off
// - external clock select makes serial clock the grayscale reference
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
module lpd_top #(
  parameter int LATCH_MAX = lpd_pkg::LATCH_MAX_OSC
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        serial_clock_in,
  input  wire logic        serial_data_in,
  output logic             serial_clock_out,
  output logic             serial_data_out,
  output logic [11:0]      sink_output,
  output logic [20:0]      group_brightness,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  localparam int LW = lpd_pkg::LATCH_W;
  localparam int IW = lpd_pkg::IDLE_W;

  // pin inputs through two flops before any use
  logic [1:0] pins_s;
  lpd_sync #(.W(2)) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({serial_clock_in, serial_data_in}),
    .sync_out (pins_s)
  );
  wire sck_s = pins_s[1];
  wire sdi_s = pins_s[0];

  logic                      sck_d;
  logic [lpd_pkg::SR_W-1:0]  shift;
  logic [LW-1:0]             latch;
  logic [7:0]                osc_div;
  logic                      latch_hold;
  logic [7:0]                osc_cnt;
  logic                      osc_lvl;
  logic [IW-1:0]             idle_ticks;
  logic [IW-1:0]             sck_period;
  logic                      frame_open;
  logic [lpd_pkg::GS_W-1:0]  gs_count;
  lpd_pkg::lpd_state_e       state;
  lpd_pkg::lpd_state_e       next_state;
  logic [11:0]               next_sink;
  logic [lpd_pkg::GS_W-1:0]  next_count;

  // serial clock edges seen on the synchronised level
  wire sck_rise = sck_s && !sck_d;
  wire sck_fall = !sck_s && sck_d;

  // internal oscillator derived from clk; osc_div sets its half period
  wire osc_tick = (osc_cnt + 8'h01 >= osc_div);
  wire osc_rise = osc_tick && !osc_lvl;
  wire osc_fall = osc_tick && osc_lvl;

  // latch bits steering the display
  wire edge_sel  = latch[lpd_pkg::BIT_EDGE_SEL];
  wire ext_clk   = latch[lpd_pkg::BIT_EXT_CLK];
  wire tmg_rst   = latch[lpd_pkg::BIT_TMG_RST];
  wire repeat_en = latch[lpd_pkg::BIT_REPEAT];
  wire blank     = latch[lpd_pkg::BIT_BLANK];

  // grayscale reference: serial clock or internal oscillator
  wire gs_rise  = ext_clk ? sck_rise : osc_rise;
  wire gs_fall  = ext_clk ? sck_fall : osc_fall;
  wire gs_event = edge_sel ? gs_rise : gs_fall;

  // latch delay scales with the last serial clock period, clamped
  wire [IW+2:0] period_x8 = {sck_period, 3'b000};
  wire [IW+2:0] max_w     = (IW+3)'(LATCH_MAX);
  wire [IW+2:0] min_w     = (IW+3)'(lpd_pkg::LATCH_MIN_OSC);
  wire [IW+2:0] thresh    = (period_x8 > max_w) ? max_w :
                            (period_x8 < min_w) ? min_w : period_x8;
  wire          idle_over = ({3'b000, idle_ticks} >= thresh);

  // frame hand-off; a full fifo stalls the latch pulse
  logic          fifo_in_ready;
  logic          fifo_out_valid;
  logic [LW-1:0] fifo_data;
  logic [4:0]    fifo_count;
  wire latch_fire = frame_open && idle_over && fifo_in_ready;
  wire apply      = fifo_out_valid && !latch_hold;

  lpd_fifo #(.W(LW), .DEPTH(lpd_pkg::FIFO_DEPTH),
             .CW(lpd_pkg::FIFO_CNT_W)) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (latch_fire),
    .in_ready  (fifo_in_ready),
    .in_data   (shift[LW-1:0]),
    .out_valid (fifo_out_valid),
    .out_ready (!latch_hold),
    .out_data  (fifo_data),
    .count     (fifo_count)
  );

  // timing reset: latch pulse with reset bit, or any change of blank
  wire new_blank = fifo_data[lpd_pkg::BIT_BLANK];
  wire new_tmg   = fifo_data[lpd_pkg::BIT_TMG_RST];
  wire tmg_reset = apply && (new_tmg || (new_blank != blank));
  wire at_last   = (gs_count == lpd_pkg::GS_LAST);

  // pwm compare per channel against latched values only
  always_comb begin
    for (int n = 0; n < lpd_pkg::CHANNELS; n++) begin
      next_sink[n] = (gs_count < lpd_pkg::gs_field(latch, n));
    end
  end

  // display period sequencing
  always_comb begin
    next_state = state;
    next_count = gs_count;
    if (tmg_reset) begin
      next_count = '0;
      next_state = new_blank ? lpd_pkg::ST_IDLE : lpd_pkg::ST_RUN;
    end else if (blank) begin
      next_count = '0;
      next_state = lpd_pkg::ST_IDLE;
    end else if (gs_event && state == lpd_pkg::ST_RUN) begin
      next_count = gs_count + 16'h0001;
      if (at_last && !repeat_en) begin
        next_state = lpd_pkg::ST_DONE;
      end
    end
  end

  // serial shift on synchronised clock rise, forwarded for cascading
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_d            <= 1'b0;
      shift            <= '0;
      serial_data_out  <= 1'b0;
      serial_clock_out <= 1'b0;
    end else begin
      sck_d            <= sck_s;
      serial_clock_out <= sck_d;
      if (sck_rise) begin
        shift           <= {shift[lpd_pkg::SR_W-2:0], sdi_s};
        serial_data_out <= shift[lpd_pkg::SR_W-1];
      end
    end
  end

  // oscillator and idle measurement in oscillator periods
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_cnt    <= '0;
      osc_lvl    <= 1'b0;
      idle_ticks <= '0;
      sck_period <= '0;
      frame_open <= 1'b0;
    end else begin
      osc_cnt <= osc_tick ? 8'h00 : osc_cnt + 8'h01;
      if (osc_tick) begin
        osc_lvl <= !osc_lvl;
      end
      if (sck_rise) begin
        idle_ticks <= '0;
        sck_period <= idle_ticks;
        frame_open <= 1'b1;
      end else begin
        if (osc_rise && idle_ticks != '1) begin
          idle_ticks <= idle_ticks + 1'b1;
        end
        if (latch_fire) begin
          frame_open <= 1'b0;
        end
      end
    end
  end

  // data latch; blank powers up set so outputs start forced off
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      latch <= LW'(1) << lpd_pkg::BIT_BLANK;
    end else if (apply) begin
      latch <= fifo_data;
    end
  end

  // counter, state and outputs; a latch pulse without reset leaves them
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gs_count    <= '0;
      state       <= lpd_pkg::ST_IDLE;
      sink_output <= '0;
    end else begin
      gs_count <= next_count;
      state    <= next_state;
      if (tmg_reset || blank) begin
        sink_output <= '0;
      end else if (gs_event) begin
        sink_output <= (state == lpd_pkg::ST_RUN) ? next_sink : 12'h000;
      end
    end
  end

  // brightness per colour group, drives the analog current dacs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      group_brightness <= '0;
    end else begin
      group_brightness <= latch[lpd_pkg::BC_LSB +: 21];
    end
  end

  // apb: one wait state, registered answer, unmapped address errors
  wire access  = psel && penable && !pready;
  wire hit_ctl = (paddr == lpd_pkg::OFF_CTRL);
  wire hit_sts = (paddr == lpd_pkg::OFF_STATUS);
  wire hit_cnt = (paddr == lpd_pkg::OFF_COUNT);
  wire mapped  = hit_ctl || hit_sts || hit_cnt;
  wire [31:0] ctrl_word = {23'h000000, latch_hold, osc_div};
  wire [31:0] sts_word  = {20'h00000, fifo_count, state,
                           edge_sel, ext_clk, tmg_rst, repeat_en, blank};
  wire [31:0] rd_word   = hit_ctl ? ctrl_word :
                          hit_sts ? sts_word :
                          hit_cnt ? {16'h0000, gs_count} : 32'h00000000;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= '0;
      osc_div    <= lpd_pkg::OSC_DIV_RST;
      latch_hold <= 1'b0;
    end else begin
      pready  <= access;
      pslverr <= access && !mapped;
      prdata  <= (access && !pwrite) ? rd_word : 32'h00000000;
      // zero divider is kept at one; it would tick every clk just the same
      if (access && pwrite && hit_ctl) begin
        osc_div    <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
        latch_hold <= pwdata[lpd_pkg::CTRL_HOLD_BIT];
      end
    end
  end

  // checks on the timing behaviour
  a_blank_forces_off: assert property (@(posedge clk) disable iff (!reset_n)
    blank |-> (sink_output == 12'h000 && gs_count == 16'h0000))
    else $error("blank set but outputs or counter not cleared");

  a_latch_resets_timing: assert property (@(posedge clk)
    disable iff (!reset_n)
    (apply && new_tmg) |=> (gs_count == 16'h0000 && sink_output == 12'h000))
    else $error("latch pulse with timing reset did not clear");

  a_latch_no_reset: assert property (@(posedge clk) disable iff (!reset_n)
    (apply && !new_tmg && new_blank == blank && !blank && !gs_event)
    |=> (gs_count == $past(gs_count) && $stable(sink_output)))
    else $error("latch pulse without timing reset disturbed display");

  a_count_needs_edge: assert property (@(posedge clk) disable iff (!reset_n)
    (!gs_event && !tmg_reset && !blank) |=> $stable(gs_count))
    else $error("counter moved without a grayscale edge");

  a_switch_on_edge: assert property (@(posedge clk) disable iff (!reset_n)
    ($changed(sink_output) && !$past(tmg_reset) && !$past(blank))
    |-> ($past(edge_sel) ? $past(gs_rise) : $past(gs_fall)))
    else $error("outputs switched off the selected edge");

  a_pwm_compare: assert property (@(posedge clk) disable iff (!reset_n)
    (gs_event && state == lpd_pkg::ST_RUN && !tmg_reset && !blank)
    |=> sink_output[0] == ($past(gs_count) < $past(latch[15:0])))
    else $error("channel zero compare wrong");

  a_repeat_wraps: assert property (@(posedge clk) disable iff (!reset_n)
    (gs_event && at_last && state == lpd_pkg::ST_RUN && !tmg_reset
     && !blank) |=> (gs_count == 16'h0000 && state == ($past(repeat_en) ?
     lpd_pkg::ST_RUN : lpd_pkg::ST_DONE)))
    else $error("period end handled wrongly");

  a_latch_delay_min: assert property (@(posedge clk) disable iff (!reset_n)
    latch_fire |-> (idle_ticks >= IW'(lpd_pkg::LATCH_MIN_OSC)))
    else $error("latch pulse too soon after last clock");

  a_cascade_data: assert property (@(posedge clk) disable iff (!reset_n)
    sck_rise |=> serial_data_out == $past(shift[lpd_pkg::SR_W-1]))
    else $error("forwarded data wrong");

  // bus answer, latch path and display timing checks
  a_ready_one_cycle: assert property (@(posedge clk)
    disable iff (!reset_n) pready |=> !pready)
    else $error("pready stood for more than one cycle");

  a_error_with_ready: assert property (@(posedge clk)
    disable iff (!reset_n) pslverr |-> pready)
    else $error("pslverr raised without pready");

  a_unmapped_zero_data: assert property (@(posedge clk)
    disable iff (!reset_n) pslverr |-> (prdata == 32'h00000000))
    else $error("refused access returned data");

  a_blank_keeps_idle: assert property (@(posedge clk)
    disable iff (!reset_n) blank |-> (state == lpd_pkg::ST_IDLE))
    else $error("blank set but display period running");

  a_ext_clock_counts: assert property (@(posedge clk)
    disable iff (!reset_n)
    (ext_clk && edge_sel && sck_rise && state == lpd_pkg::ST_RUN
     && !tmg_reset && !blank) |=> (gs_count == $past(gs_count) + 16'h0001))
    else $error("serial clock rise did not advance the counter");

  a_hold_freezes_latch: assert property (@(posedge clk)
    disable iff (!reset_n) latch_hold |=> $stable(latch))
    else $error("latch changed while the drain was held");

  a_latch_only_on_pulse: assert property (@(posedge clk)
    disable iff (!reset_n) !apply |=> $stable(latch))
    else $error("latch changed without a latch pulse");

  a_blank_change_resets: assert property (@(posedge clk)
    disable iff (!reset_n) (apply && new_blank != blank)
    |=> (gs_count == 16'h0000 && sink_output == 12'h000))
    else $error("blank change did not clear counter and outputs");

  a_fire_closes_frame: assert property (@(posedge clk)
    disable iff (!reset_n) (latch_fire && !sck_rise) |=> !frame_open)
    else $error("frame still open after its latch pulse");
endmodule // lpd_top

// >>> tb/lpd_host.sv
// host controller model driving serial frames into the display block
`timescale 1ns/100ps
module lpd_host (
  input  logic clk,
  output logic serial_clock_in,
  output logic serial_data_in
);
  // clock idles low between frames, it never runs free
  initial begin
    serial_clock_in = 1'b0;
    serial_data_in  = 1'b0;
  end

  // msb first, 8 clk (400 ns) per bit, all changes just after a clk rise;
  // data moves with the falling serial clock so it is steady at the rise
  // a short frame sends only the low n bits of f
  task automatic send(input logic [223:0] f, input int n);
    @(posedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_in <= f[i];
      repeat (4) @(posedge clk);
      serial_clock_in <= 1'b1;
      repeat (4) @(posedge clk);
      serial_clock_in <= 1'b0;
    end
    // released line must not keep showing the last bit
    serial_data_in <= ~f[0];
  endtask
endmodule // lpd_host

// >>> tb/lpd_top_tb.sv
// self-checking bench for the led display-timing block
`timescale 1ns/100ps
module lpd_top_tb;
  localparam logic [5:0]  WRITE_CMD = 6'h25; // arbitrary, not decoded
  localparam logic [20:0] BC_VAL    = 21'h0a5a5a;
  typedef struct {
    logic [4:0]  ctl;
    logic [15:0] gse;
    logic [15:0] gso;
    logic [11:0] sink;
    logic [1:0]  st;
    logic        clr;
  } lpd_tb_row_s;
  logic        clk, reset_n, sck, sdi, sco, sdo, e;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] sink;
  logic [20:0] bc;
  logic [15:0] prev;
  logic [223:0] f;
  logic        pf0;
  int          err_count, n_tests;
  int          sco_rises = 0;
  // ctl = {edge_sel, ext_clk, timing_reset, repeat, blank}
  lpd_tb_row_s rows [6] = '{
    '{5'b10100, 16'hffff, 16'h0000, 12'h555, 2'b01, 1'b1},
    '{5'b00110, 16'h0000, 16'hffff, 12'haaa, 2'b01, 1'b1},
    '{5'b00101, 16'hffff, 16'hffff, 12'h000, 2'b00, 1'b1},
    '{5'b10000, 16'hffff, 16'hffff, 12'hfff, 2'b01, 1'b1},
    '{5'b11100, 16'hffff, 16'h0000, 12'h000, 2'b01, 1'b1},
    '{5'b10000, 16'h0000, 16'h0000, 12'h000, 2'b01, 1'b0}
  };

  lpd_host host (.clk(clk), .serial_clock_in(sck), .serial_data_in(sdi));

  // forwarded clock pulses, counted for the cascade check
  always @(posedge sco) sco_rises++;

  // small latch ceiling keeps the run short
  lpd_top #(.LATCH_MAX(64)) dut (
    .clk(clk), .reset_n(reset_n),
    .serial_clock_in(sck), .serial_data_in(sdi),
    .serial_clock_out(sco), .serial_data_out(sdo),
    .sink_output(sink), .group_brightness(bc),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic close_out;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      $display("wrong value %s expected %h seen %h", nm, x, g);
      err_count++;
    end
  endtask

  // one apb transfer; pready, read data and error taken at the same rise
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic er);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      $display("wrong value pready expected 1 seen 0");
      err_count++;
    end
    r  = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [223:0] mk(input logic [4:0] ctl,
                                      input logic [15:0] ge, go);
    logic [191:0] g;
    for (int c = 0; c < 12; c++) g[c*16 +: 16] = c[0] ? go : ge;
    mk = {WRITE_CMD, ctl, BC_VAL, g};
  endfunction

  // frame then a wait past the longest latch delay
  task automatic frame(input logic [223:0] fr, input int n);
    host.send(fr, n);
    repeat (150) @(posedge clk);
    @(negedge clk);
  endtask

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_count = 0;
    n_tests = 0;
    prev = 16'h0000;
    pf0 = 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (rows[i]) begin
      frame(mk(rows[i].ctl, rows[i].gse, rows[i].gso), 224);
      chk("sink", rows[i].sink, sink);
      chk("bright", BC_VAL, bc);
      // forwarded bit trails by one stage: last bit of the frame before
      chk("forward", {1'b0, pf0}, {sco, sdo});
      pf0 = rows[i].gse[0];
      apb(1'b0, lpd_pkg::OFF_STATUS, 32'h0, rd, e);
      chk("no_error", 0, e);
      chk("ctl", rows[i].ctl, rd[4:0]);
      chk("state", rows[i].st, rd[6:5]);
      apb(1'b0, lpd_pkg::OFF_COUNT, 32'h0, rd, e);
      if (rows[i].clr) begin
        chk("count_low", 1, rd[15:0] < 16'h0064);
      end else begin
        chk("count_grow", 1, rd[15:0] > prev);
      end
      prev = rd[15:0];
    end
    chk("fwd_clocks", 1344, sco_rises);
    // unmapped place answers with an error and zero data
    apb(1'b0, 8'h0c, 32'h0, rd, e);
    chk("slverr", 1, e);
    chk("unmapped", 32'h0, rd);
    // hold the drain and queue frames until the fifo refuses
    apb(1'b1, lpd_pkg::OFF_CTRL, 32'h100, rd, e);
    apb(1'b0, lpd_pkg::OFF_CTRL, 32'h0, rd, e);
    chk("ctrl", 32'h101, rd); // zero divider reads back as one
    for (int k = 0; k < 17; k++) begin
      frame(mk(k == 16 ? 5'b00010 : 5'b10100, 16'hffff, 16'h0), 224);
    end
    apb(1'b0, lpd_pkg::OFF_STATUS, 32'h0, rd, e);
    chk("fifo_full", 16, rd[11:7]);
    chk("held", 5'b10000, rd[4:0]);
    chk("held_sink", 12'h000, sink);
    apb(1'b1, lpd_pkg::OFF_CTRL, 32'h001, rd, e);
    repeat (50) @(posedge clk);
    apb(1'b0, lpd_pkg::OFF_STATUS, 32'h0, rd, e);
    chk("fifo_empty", 0, rd[11:7]);
    chk("drained", 5'b00010, rd[4:0]);
    // short frame still latches the last 218 bits shifted
    f = mk(5'b00000, 16'h0, 16'h0);
    f[113] = 1'b1;
    frame(f, 224);
    frame(224'h0, 100);
    apb(1'b0, lpd_pkg::OFF_STATUS, 32'h0, rd, e);
    chk("short", 5'b00001, rd[4:0]);
    chk("short_sink", 12'h000, sink);
    // second reset in mid-run
    reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk("rst_sink", 12'h000, sink);
    apb(1'b0, lpd_pkg::OFF_STATUS, 32'h0, rd, e);
    chk("rst_blank", 1, rd[0]);
    apb(1'b0, lpd_pkg::OFF_CTRL, 32'h0, rd, e);
    chk("rst_ctrl", 32'h001, rd);
    close_out;
  end

  // watchdog: the whole sequence needs about 50000 cycles
  initial begin
    repeat (80000) @(posedge clk);
    err_count++;
    close_out;
  end
endmodule // lpd_top_tb
